// ===== logic/pcs_pkg.sv
// Purpose: Shared constants, state types and register map of the processor supervisor companion
// Assumes: 100 MHz clk_sys, two-wire register access, analog comparators delivered as digital levels
// Notes:
// Summary of operation
// - Low supply drives reset low
// - Hold reset 100 ms after supply recovers
// - Ignore bus while reset asserted
// - Trip select bit chooses 3.9V or 4.4V
// - Five-bit watchdog period, 100 ms steps
// - Watchdog resets only when enabled and expired
// - Disabled watchdog still runs and flags fault
// - Any reset restarts the watchdog
// - All-ones period stops the watchdog counter
// - Kick pattern restarts watchdog, loads period
// - Period bits 4-0, enable bit 7
// - Watchdog held off during low supply
// - External low on reset pin gives 100 ms reset
// - Sticky reset source flags, software cleared
// - Warning output low below reference
// - Two 16-bit edge counters at mapped bytes
// - Snapshot request latches all counter bytes
// - Counter writes load values, block counting
// - Cascade makes one 32-bit counter
// - Polarity bits pick each counter edge
// - Serial bytes writable until lock set
package pcs_pkg;

  // Timing
  localparam int CLK_KHZ      = 100_000;
  localparam int RST_HOLD_MS  = 100;
  localparam int RST_HOLD_CYC = RST_HOLD_MS * CLK_KHZ;
  localparam int WD_STEP_MS   = 100;
  localparam int WD_STEP_CYC  = WD_STEP_MS * CLK_KHZ;
  localparam int MR_FILT_US   = 10;
  localparam int MR_FILT_CYC  = (MR_FILT_US * CLK_KHZ + 999) / 1000;
  localparam int TMR_W        = 24;
  localparam int MR_W         = 12;

  // Register offsets
  localparam logic [7:0] ADR_WD_FLAGS  = 8'h09;
  localparam logic [7:0] ADR_WD_CTL    = 8'h0A;
  localparam logic [7:0] ADR_COMP_CTL  = 8'h0B;
  localparam logic [7:0] ADR_EV_CTL    = 8'h0C;
  localparam logic [7:0] ADR_CNT_A_LO  = 8'h0D;
  localparam logic [7:0] ADR_CNT_A_HI  = 8'h0E;
  localparam logic [7:0] ADR_CNT_B_LO  = 8'h0F;
  localparam logic [7:0] ADR_CNT_B_HI  = 8'h10;
  localparam logic [7:0] ADR_SER_FIRST = 8'h11;
  localparam logic [7:0] ADR_SER_LAST  = 8'h18;

  // Field positions
  localparam int BIT_WD_FAULT = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_WD_EN    = 7;
  localparam int BIT_SER_LOCK = 7;
  localparam int BIT_TRIP_SEL = 0;
  localparam int BIT_SNAP     = 3;
  localparam int BIT_CASC     = 2;
  localparam int BIT_POL_B    = 1;
  localparam int BIT_POL_A    = 0;

  // Values
  localparam logic [3:0] KICK_PATTERN  = 4'hA;
  localparam logic [4:0] WD_PERIOD_OFF = 5'h1F;
  localparam logic [7:0] COMP_KEEP     = 8'h3D;
  localparam logic [4:0] WD_PERIOD_RST = 5'h1F;
  localparam logic [7:0] COMP_CTL_RST  = 8'h00;

  // Synchronised pin indices
  localparam int PIN_N   = 8;
  localparam int I_SCL   = 0;
  localparam int I_SDA   = 1;
  localparam int I_RST   = 2;
  localparam int I_PF    = 3;
  localparam int I_EVA   = 4;
  localparam int I_EVB   = 5;
  localparam int I_SUPLO = 6;
  localparam int I_SUPHI = 7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h2,
    ST_REG  = 3'h3,
    ST_WACK = 3'h4,
    ST_WR   = 3'h5,
    ST_RD   = 3'h6,
    ST_RACK = 3'h7
  } pcs_bus_st_t;

  typedef struct packed {
    logic [PIN_N-1:0][2:0] sy;
    logic [PIN_N-1:0]      lv;
    pcs_bus_st_t           bus_st;
    logic [3:0]            bit_cnt;
    logic [7:0]            shreg;
    logic [7:0]            ptr;
    logic                  rw;
    logic                  sda_oe_n;
    logic [TMR_W-1:0]      hold;
    logic                  rst_drive;
    logic                  rst_oe_n;
    logic [MR_W-1:0]       mr_cnt;
    logic [TMR_W-1:0]      wd_pre;
    logic [4:0]            wd_steps;
    logic [4:0]            wd_load;
    logic                  wd_fault;
    logic                  low_flag;
    logic                  wd_en;
    logic [4:0]            wd_period;
    logic [7:0]            comp_ctl;
    logic [3:0]            ev_ctl;
    logic [15:0]           cnt_a;
    logic [15:0]           cnt_b;
    logic [31:0]           snap;
    logic                  pend_a;
    logic                  pend_b;
    logic [7:0][7:0]       serial;
    logic                  pf_ok;
  } pcs_state_t;

  // Pins sampled from outside the clock domain
  typedef struct packed {
    logic sup_below_hi;
    logic sup_below_lo;
    logic event_in_b;
    logic event_in_a;
    logic pf_below_ref;
    logic rst_pin;
    logic sda;
    logic scl;
  } pcs_pins_t;

endpackage

// ===== logic/pcs_companion.sv
// Purpose: Supervisor, watchdog, manual reset, event counters, serial number and two-wire register slave
// Assumes: Comparator results arrive as digital levels; pins are asynchronous to clk_sys
// Notes: Open-drain pins drive low only; enable is active low
`timescale 1ns/10ps

module pcs_companion
  import pcs_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR        = 7'h68,  // Arbitrary value
  parameter int unsigned P_RST_HOLD_CYC  = RST_HOLD_CYC,
  parameter int unsigned P_WD_STEP_CYC   = WD_STEP_CYC,
  parameter int unsigned P_MR_FILT_CYC   = MR_FILT_CYC
) (
  // Clock and reset
  input  wire logic      clk_sys,
  input  wire logic      reset,
  // Pins in
  input  wire pcs_pins_t pins_in,
  // Reset pin, open drain
  output logic           rst_out,
  output logic           rst_oe_n,
  // Two-wire data pin, open drain
  output logic           sda_out,
  output logic           sda_oe_n,
  // Power-fail warning
  output logic           pf_warn_out
);

  pcs_state_t       r_q;
  pcs_state_t       r_d;

  logic [PIN_N-1:0] pin_v;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_c;
  logic             stop_c;
  logic             bus_lock;
  logic             supply_low;
  logic             wr_en;
  logic [7:0]       wr_dat;
  logic [7:0]       rd_val;
  logic             kick;
  logic             ev_a;
  logic             ev_b;
  logic             inc_a;
  logic             inc_b;
  logic             cnt_block;
  logic [4:0]       wd_lim;
  logic             wd_expire;
  logic             mr_trig;
  logic [31:0]      casc;

  function automatic logic [7:0] rd_byte(input pcs_state_t s, input logic [7:0] a);
    logic [7:0] v;
    logic [2:0] idx;
    v   = 8'h00;
    idx = 3'(a - ADR_SER_FIRST);
    if (a == ADR_WD_FLAGS) begin
      v[BIT_WD_FAULT] = s.wd_fault;
      v[BIT_LOW_FLAG] = s.low_flag;
    end else if (a == ADR_WD_CTL) begin
      v[BIT_WD_EN] = s.wd_en;
      v[4:0]       = s.wd_period;
    end else if (a == ADR_COMP_CTL) begin
      v = s.comp_ctl;
    end else if (a == ADR_EV_CTL) begin
      v[3:0] = s.ev_ctl;
    end else if (a == ADR_CNT_A_LO) begin
      v = s.snap[7:0];
    end else if (a == ADR_CNT_A_HI) begin
      v = s.snap[15:8];
    end else if (a == ADR_CNT_B_LO) begin
      v = s.snap[23:16];
    end else if (a == ADR_CNT_B_HI) begin
      v = s.snap[31:24];
    end else if (a >= ADR_SER_FIRST && a <= ADR_SER_LAST) begin
      v = s.serial[idx];
    end
    return v;
  endfunction

  assign pin_v = pins_in;

  always_comb begin
    r_d = r_q;
    wr_en = 1'b0;
    wr_dat = r_q.shreg;
    kick = 1'b0;

    // Three-flop synchronisers, level moves once the last two agree
    for (int i = 0; i < PIN_N; i++) begin
      r_d.sy[i] = {r_q.sy[i][1:0], pin_v[i]};
      if (r_q.sy[i][2] == r_q.sy[i][1]) begin
        r_d.lv[i] = r_q.sy[i][2];
      end
    end

    scl_rise   = r_d.lv[I_SCL] & ~r_q.lv[I_SCL];
    scl_fall   = ~r_d.lv[I_SCL] & r_q.lv[I_SCL];
    start_c    = r_q.lv[I_SCL] & r_d.lv[I_SCL] & r_q.lv[I_SDA] & ~r_d.lv[I_SDA];
    stop_c     = r_q.lv[I_SCL] & r_d.lv[I_SCL] & ~r_q.lv[I_SDA] & r_d.lv[I_SDA];
    supply_low = r_q.comp_ctl[BIT_TRIP_SEL] ? r_q.lv[I_SUPHI] : r_q.lv[I_SUPLO];
    bus_lock   = r_q.rst_drive | ~r_q.lv[I_RST];
    rd_val     = rd_byte(r_q, r_q.ptr);

    // Two-wire slave
    if (bus_lock) begin
      r_d.bus_st   = ST_IDLE;
      r_d.sda_oe_n = 1'b1;
    end else if (start_c) begin
      r_d.bus_st   = ST_ADDR;
      r_d.bit_cnt  = 4'h0;
      r_d.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      r_d.bus_st   = ST_IDLE;
      r_d.sda_oe_n = 1'b1;
    end else begin
      unique case (r_q.bus_st)
        ST_IDLE: begin
        end
        ST_ADDR, ST_REG, ST_WR: begin
          if (scl_rise) begin
            r_d.shreg   = {r_q.shreg[6:0], r_q.lv[I_SDA]};
            r_d.bit_cnt = r_q.bit_cnt + 4'h1;
          end else if (scl_fall && r_q.bit_cnt == 4'h8) begin
            r_d.bit_cnt  = 4'h0;
            r_d.sda_oe_n = 1'b0;
            r_d.bus_st   = ST_WACK;
            if (r_q.bus_st == ST_ADDR) begin
              if (r_q.shreg[7:1] == DEV_ADDR) begin
                r_d.rw     = r_q.shreg[0];
                r_d.bus_st = ST_AACK;
              end else begin
                r_d.sda_oe_n = 1'b1;
                r_d.bus_st   = ST_IDLE;
              end
            end else if (r_q.bus_st == ST_REG) begin
              r_d.ptr = r_q.shreg;
            end else begin
              // Write commits here even if a reset starts next cycle
              wr_en   = 1'b1;
              r_d.ptr = r_q.ptr + 8'h01;
            end
          end
        end
        ST_AACK, ST_WACK: begin
          if (scl_fall) begin
            r_d.sda_oe_n = 1'b1;
            if (r_q.bus_st == ST_AACK && r_q.rw) begin
              r_d.shreg    = rd_val;
              r_d.ptr      = r_q.ptr + 8'h01;
              r_d.sda_oe_n = rd_val[7];
              r_d.bus_st   = ST_RD;
            end else if (r_q.bus_st == ST_AACK) begin
              r_d.bus_st = ST_REG;
            end else begin
              r_d.bus_st = ST_WR;
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (r_q.bit_cnt == 4'h7) begin
              r_d.bit_cnt  = 4'h0;
              r_d.sda_oe_n = 1'b1;
              r_d.bus_st   = ST_RACK;
            end else begin
              r_d.shreg    = {r_q.shreg[6:0], 1'b0};
              r_d.bit_cnt  = r_q.bit_cnt + 4'h1;
              r_d.sda_oe_n = r_q.shreg[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && r_q.lv[I_SDA]) begin
            r_d.bus_st = ST_IDLE;
          end else if (scl_fall) begin
            r_d.shreg    = rd_val;
            r_d.ptr      = r_q.ptr + 8'h01;
            r_d.sda_oe_n = rd_val[7];
            r_d.bus_st   = ST_RD;
          end
        end
      endcase
    end

    // Event counters; an edge seen while blocked waits in the pending bit
    ev_a  = r_q.ev_ctl[BIT_POL_A] ? (r_q.lv[I_EVA] & ~r_d.lv[I_EVA])
                                  : (~r_q.lv[I_EVA] & r_d.lv[I_EVA]);
    ev_b  = r_q.ev_ctl[BIT_POL_B] ? (r_q.lv[I_EVB] & ~r_d.lv[I_EVB])
                                  : (~r_q.lv[I_EVB] & r_d.lv[I_EVB]);
    inc_a = r_q.pend_a | ev_a;
    inc_b = (r_q.pend_b | ev_b) & ~r_q.ev_ctl[BIT_CASC];
    cnt_block = (r_q.bus_st == ST_WR || wr_en) && r_q.ptr >= ADR_CNT_A_LO && r_q.ptr <= ADR_CNT_B_HI;
    casc = {r_q.cnt_b, r_q.cnt_a} + 32'h0000_0001;
    if (cnt_block) begin
      r_d.pend_a = inc_a;
      r_d.pend_b = inc_b;
    end else begin
      r_d.pend_a = 1'b0;
      r_d.pend_b = 1'b0;
      if (r_q.ev_ctl[BIT_CASC]) begin
        if (inc_a) begin
          {r_d.cnt_b, r_d.cnt_a} = casc;
        end
      end else begin
        if (inc_a) begin
          r_d.cnt_a = r_q.cnt_a + 16'h0001;
        end
        if (inc_b) begin
          r_d.cnt_b = r_q.cnt_b + 16'h0001;
        end
      end
    end

    // Register writes
    if (wr_en) begin
      if (r_q.ptr == ADR_WD_FLAGS) begin
        r_d.wd_fault = r_q.wd_fault & wr_dat[BIT_WD_FAULT];
        r_d.low_flag = r_q.low_flag & wr_dat[BIT_LOW_FLAG];
        kick         = (wr_dat[3:0] == KICK_PATTERN);
      end else if (r_q.ptr == ADR_WD_CTL) begin
        r_d.wd_en     = wr_dat[BIT_WD_EN];
        r_d.wd_period = wr_dat[4:0];
      end else if (r_q.ptr == ADR_COMP_CTL) begin
        r_d.comp_ctl = wr_dat & COMP_KEEP;
        r_d.comp_ctl[BIT_SER_LOCK] = r_q.comp_ctl[BIT_SER_LOCK] | wr_dat[BIT_SER_LOCK];
      end else if (r_q.ptr == ADR_EV_CTL) begin
        r_d.ev_ctl = wr_dat[3:0];
        if (wr_dat[BIT_SNAP]) begin
          r_d.snap = {r_q.cnt_b, r_q.cnt_a};
        end
      end else if (r_q.ptr == ADR_CNT_A_LO) begin
        r_d.cnt_a[7:0] = wr_dat;
      end else if (r_q.ptr == ADR_CNT_A_HI) begin
        r_d.cnt_a[15:8] = wr_dat;
      end else if (r_q.ptr == ADR_CNT_B_LO) begin
        r_d.cnt_b[7:0] = wr_dat;
      end else if (r_q.ptr == ADR_CNT_B_HI) begin
        r_d.cnt_b[15:8] = wr_dat;
      end else if (r_q.ptr >= ADR_SER_FIRST && r_q.ptr <= ADR_SER_LAST
                   && !r_q.comp_ctl[BIT_SER_LOCK]) begin
        r_d.serial[3'(r_q.ptr - ADR_SER_FIRST)] = wr_dat;
      end
    end

    // Watchdog
    wd_lim    = (r_q.wd_load == 5'h00) ? 5'h01 : r_q.wd_load;
    wd_expire = 1'b0;
    if (r_q.rst_drive || supply_low || kick) begin
      r_d.wd_pre   = '0;
      r_d.wd_steps = 5'h00;
      r_d.wd_load  = r_d.wd_period;
    end else if (r_q.wd_period != WD_PERIOD_OFF) begin
      if (r_q.wd_pre == TMR_W'(P_WD_STEP_CYC - 1)) begin
        r_d.wd_pre   = '0;
        r_d.wd_steps = r_q.wd_steps + 5'h01;
        if (r_q.wd_steps + 5'h01 >= wd_lim) begin
          wd_expire    = 1'b1;
          r_d.wd_steps = 5'h00;
          r_d.wd_load  = r_q.wd_period;
        end
      end else begin
        r_d.wd_pre = r_q.wd_pre + TMR_W'(1);
      end
    end

    // Manual reset filter; our own drive is excluded so release cannot retrigger
    mr_trig = 1'b0;
    if (!r_q.lv[I_RST] && !r_q.rst_drive) begin
      r_d.mr_cnt = r_q.mr_cnt + MR_W'(1);
      mr_trig    = (r_q.mr_cnt == MR_W'(P_MR_FILT_CYC - 1));
    end else begin
      r_d.mr_cnt = '0;
    end

    // Reset hold and source flags; hardware set wins over software clear
    if (supply_low || mr_trig || (wd_expire && r_q.wd_en)) begin
      r_d.hold = TMR_W'(P_RST_HOLD_CYC);
    end else if (r_q.hold != '0) begin
      r_d.hold = r_q.hold - TMR_W'(1);
    end
    if (supply_low || mr_trig) begin
      r_d.low_flag = 1'b1;
    end
    if (wd_expire) begin
      r_d.wd_fault = 1'b1;
    end
    r_d.rst_drive = (r_d.hold != '0) | supply_low;
    r_d.rst_oe_n  = ~r_d.rst_drive;
    r_d.pf_ok     = ~r_q.lv[I_PF];

    if (reset) begin
      r_d           = '0;
      r_d.lv        = '1;
      r_d.lv[I_EVA] = 1'b0;
      r_d.lv[I_EVB] = 1'b0;
      r_d.lv[I_PF]  = 1'b0;
      r_d.sda_oe_n  = 1'b1;
      r_d.rst_oe_n  = 1'b1;
      r_d.pf_ok     = 1'b1;
      r_d.wd_period = WD_PERIOD_RST;
      r_d.wd_load   = WD_PERIOD_RST;
      r_d.comp_ctl  = COMP_CTL_RST;
      r_d.lv[I_SUPLO] = 1'b0;
      r_d.lv[I_SUPHI] = 1'b0;
      // Flops start at the idle levels so release cannot fake an edge or a low supply
      for (int i = 0; i < PIN_N; i++) begin
        r_d.sy[i] = {3{r_d.lv[i]}};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    r_q <= r_d;
  end

  assign rst_out     = 1'b0;
  assign rst_oe_n    = r_q.rst_oe_n;
  assign sda_out     = 1'b0;
  assign sda_oe_n    = r_q.sda_oe_n;
  assign pf_warn_out = r_q.pf_ok;

endmodule

// ===== test/pcs_companion_assertions.sv
// Purpose: Port-level checks for the companion
// Assumes: Short sim counts, pins as the design sees them
// Notes: Counts below are in clk_sys cycles
`timescale 1ns/10ps

module pcs_companion_assertions
  import pcs_pkg::*;
#(
  parameter int unsigned P_RST_HOLD_CYC = 200,
  parameter int unsigned P_MR_FILT_CYC  = 8
) (
  // Clock and reset
  input wire logic      clk_sys,
  input wire logic      reset,
  // Watched ports
  input wire pcs_pins_t pins_in,
  input wire logic      rst_out,
  input wire logic      rst_oe_n,
  input wire logic      sda_out,
  input wire logic      sda_oe_n,
  input wire logic      pf_warn_out
);
  localparam int MR_MAX = P_MR_FILT_CYC + 6;
  int low_q;
  int rel_q;

  // Low time of the reset output enable, and low time since supply came good
  always_ff @(posedge clk_sys) begin
    if (reset || rst_oe_n) begin
      low_q <= 0;
      rel_q <= 0;
    end else begin
      low_q <= low_q + 1;
      rel_q <= pins_in.sup_below_hi ? 0 : rel_q + 1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_sup_low;
    pins_in.sup_below_lo [*6] |=> !rst_oe_n;
  endproperty
  a_sup_low: assert property (p_sup_low) else $error("no reset on low supply");
  property p_hold_min;
    $rose(rst_oe_n) |-> low_q >= int'(P_RST_HOLD_CYC);
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("reset released early");
  property p_hold_max;
    !rst_oe_n |-> rel_q <= int'(P_RST_HOLD_CYC) + 10;
  endproperty
  a_hold_max: assert property (p_hold_max) else $error("reset held too long");
  property p_lockout;
    !rst_oe_n [*2] |-> sda_oe_n;
  endproperty
  a_lockout: assert property (p_lockout) else $error("bus answered during reset");
  property p_manual;
    (!pins_in.rst_pin) [*8] |-> ##[0:MR_MAX] !rst_oe_n;
  endproperty
  a_manual: assert property (p_manual) else $error("manual low not followed");
  property p_pf_low;
    pins_in.pf_below_ref [*5] |=> !pf_warn_out;
  endproperty
  a_pf_low: assert property (p_pf_low) else $error("warning not low");
  property p_pf_high;
    !pins_in.pf_below_ref [*5] |=> pf_warn_out;
  endproperty
  a_pf_high: assert property (p_pf_high) else $error("warning not high");
  property p_sda_chg;
    $changed(sda_oe_n) && rst_oe_n && pins_in.rst_pin |-> !pins_in.scl && !sda_out && !rst_out;
  endproperty
  a_sda_chg: assert property (p_sda_chg) else $error("data moved with clock high");
endmodule

// ===== test/pcs_host_model.sv
// Purpose: Host processor on the two-wire bus
// Assumes: Pull-up on data, so a released line reads high
// Notes: Eight-cycle phases leave room for the pin filters
`timescale 1ns/10ps

module pcs_host_model #(
  parameter logic [6:0] ADDR = 7'h68  // Arbitrary value
) (
  // Clock
  input wire logic clk_sys,
  // Bus
  input wire logic sda_in,
  output logic     scl,
  output logic     sda_o
);
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end

  task automatic hc(input int c);
    repeat (c) @(negedge clk_sys);
  endtask

  task automatic cb(input logic b, output logic r);
    sda_o = b;
    hc(8);
    scl = 1'b1;
    hc(6);
    r = sda_in;
    hc(2);
    scl = 1'b0;
    hc(2);
  endtask

  // Also serves as repeated start
  task automatic start;
    sda_o = 1'b1;
    hc(8);
    scl = 1'b1;
    hc(8);
    sda_o = 1'b0;
    hc(8);
    scl = 1'b0;
    hc(2);
  endtask

  task automatic stop;
    sda_o = 1'b0;
    hc(8);
    scl = 1'b1;
    hc(8);
    sda_o = 1'b1;
    hc(8);
  endtask

  task automatic wb(input logic [7:0] v, inout logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      cb(v[i], r);
    end
    cb(1'b1, r);
    ok = ok & ~r;
  endtask

  task automatic wreg(input logic [7:0] a, v, output logic ok);
    ok = 1'b1;
    start;
    wb({ADDR, 1'b0}, ok);
    wb(a, ok);
    wb(v, ok);
    stop;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [7:0] v, output logic ok);
    logic r;
    ok = 1'b1;
    start;
    wb({ADDR, 1'b0}, ok);
    wb(a, ok);
    start;
    wb({ADDR, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      cb(1'b1, v[i]);
    end
    // Not acknowledging ends the read
    cb(1'b1, r);
    stop;
  endtask
endmodule

// ===== test/pcs_companion_tb_top.sv
// Purpose: Self-checking bench for the companion
// Assumes: Host model on the bus, comparators driven as levels
// Notes: Short counts keep each wait in the low thousands of cycles
`timescale 1ns/10ps

module pcs_companion_tb_top;
  import pcs_pkg::*;
  localparam int unsigned HOLD = 200;
  localparam int unsigned STEP = 50;
  localparam int unsigned FILT = 8;
  logic       clk_sys = 1'b0;
  logic       reset, ext_low, pf_lo, sup_lo, sup_hi, ev_a, ev_b;
  logic       scl, sda_h, sda_w, rst_w, ok;
  logic       rst_out, rst_oe_n, sda_out, sda_oe_n, pf_warn_out;
  logic [7:0] d;
  pcs_pins_t  pins;
  int         errors  = 0;
  int         n_tests = 0;
  int         n;

  always #5 clk_sys = ~clk_sys;
  // Wired levels of the two open-drain lines
  assign rst_w = (rst_oe_n ? 1'b1 : rst_out) & ~ext_low;
  assign sda_w = (sda_oe_n ? 1'b1 : sda_out) & sda_h;
  assign pins  = '{sup_hi, sup_lo, ev_b, ev_a, pf_lo, rst_w, sda_w, scl};

  pcs_companion #(.P_RST_HOLD_CYC(HOLD), .P_WD_STEP_CYC(STEP), .P_MR_FILT_CYC(FILT)) dut (
    .clk_sys(clk_sys), .reset(reset), .pins_in(pins), .rst_out(rst_out), .rst_oe_n(rst_oe_n),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pf_warn_out(pf_warn_out));
  pcs_host_model host (.clk_sys(clk_sys), .sda_in(sda_w), .scl(scl), .sda_o(sda_h));

  task automatic chk(input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    host.wreg(a, v, ok);
    chk(ok, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    host.rreg(a, d, ok);
    chk({ok, d}, {1'b1, exp});
  endtask
  task automatic wt(input logic v, input int mx);
    n = 0;
    while (rst_oe_n !== v && n < mx) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic ld(input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      wr(ADR_CNT_A_LO + 8'(i), v[8*i +: 8]);
    end
  endtask
  task automatic cnt(input logic [7:0] ctl, input logic [31:0] v);
    wr(ADR_EV_CTL, ctl | 8'h08);
    for (int i = 0; i < 4; i++) begin
      rd(ADR_CNT_A_LO + 8'(i), v[8*i +: 8]);
    end
  endtask
  task automatic pul(input int na, nb);
    for (int i = 0; i < 3; i++) begin
      ev_a = (i < na);
      ev_b = (i < nb);
      host.hc(10);
      ev_a = 1'b0;
      ev_b = 1'b0;
      host.hc(10);
    end
  endtask

  task automatic t_regs;
    rd(ADR_WD_CTL, 8'h1F);
    rd(ADR_COMP_CTL, 8'h00);
    rd(8'h05, 8'h00);
    wr(ADR_WD_CTL, 8'h9F);
    rd(ADR_WD_CTL, 8'h9F);
  endtask
  task automatic t_wdog;
    wr(ADR_WD_CTL, 8'h14);
    wr(ADR_WD_FLAGS, 8'h0A);
    wr(ADR_WD_CTL, 8'h94);
    wt(1'b0, 700);
    chk(n >= 380 && n <= 480, 1);
    wt(1'b1, 300);
    chk(n >= HOLD && n <= HOLD + 10, 1);
    wt(1'b0, 1100);
    chk(n >= 990 && n <= 1060, 1);
    wt(1'b1, 300);
    wr(ADR_WD_CTL, 8'h14);
    rd(ADR_WD_FLAGS, 8'h80);
    wr(ADR_WD_FLAGS, 8'h0A);
    rd(ADR_WD_FLAGS, 8'h00);
    wt(1'b0, 600);
    chk(n, 600);
    rd(ADR_WD_FLAGS, 8'h80);
    wr(ADR_WD_CTL, 8'h1F);
    wr(ADR_WD_FLAGS, 8'h0A);
    wt(1'b0, 1500);
    rd(ADR_WD_FLAGS, 8'h00);
  endtask
  task automatic t_sup;
    sup_lo = 1'b1;
    sup_hi = 1'b1;
    wt(1'b0, 10);
    chk(n < 10, 1);
    host.wreg(ADR_SER_FIRST, 8'h77, ok);
    chk(ok, 1'b0);
    sup_lo = 1'b0;
    sup_hi = 1'b0;
    wt(1'b1, 300);
    chk(n >= HOLD && n <= HOLD + 10, 1);
    rd(ADR_WD_FLAGS, 8'h40);
    rd(ADR_SER_FIRST, 8'h00);
    wr(ADR_COMP_CTL, 8'h03);
    rd(ADR_COMP_CTL, 8'h01);
    sup_hi = 1'b1;
    wt(1'b0, 10);
    chk(n < 10, 1);
    sup_hi = 1'b0;
    wt(1'b1, 300);
    wr(ADR_COMP_CTL, 8'h00);
    sup_hi = 1'b1;
    wt(1'b0, 30);
    chk(n, 30);
    sup_hi = 1'b0;
  endtask
  task automatic t_man;
    wr(ADR_WD_FLAGS, 8'h00);
    ext_low = 1'b1;
    host.hc(20);
    chk(rst_oe_n, 1'b0);
    ext_low = 1'b0;
    wt(1'b1, 300);
    chk(n >= HOLD - 20 && n <= HOLD, 1);
    rd(ADR_WD_FLAGS, 8'h40);
    pf_lo = 1'b1;
    host.hc(8);
    chk(pf_warn_out, 1'b0);
    pf_lo = 1'b0;
    host.hc(8);
    chk(pf_warn_out, 1'b1);
  endtask
  // Polarity is set before each load; edges come from level changes only, so changing it cannot count
  task automatic t_cnt;
    wr(ADR_EV_CTL, 8'h00);
    ld(32'h0000_0000);
    pul(3, 2);
    cnt(8'h00, 32'h0002_0003);
    wr(ADR_EV_CTL, 8'h01);
    ld(32'h0000_0000);
    ev_a = 1'b1;
    host.hc(10);
    cnt(8'h01, 32'h0000_0000);
    ev_a = 1'b0;
    host.hc(10);
    cnt(8'h01, 32'h0000_0001);
    wr(ADR_EV_CTL, 8'h04);
    ld(32'h0000_FFFF);
    pul(1, 1);
    cnt(8'h04, 32'h0001_0000);
    pul(1, 0);
    rd(ADR_CNT_A_LO, 8'h00);
    wr(ADR_EV_CTL, 8'h02);
    ld(32'h0000_0000);
    pul(0, 1);
    cnt(8'h02, 32'h0001_0000);
  endtask
  task automatic t_ser;
    wr(ADR_SER_FIRST, 8'h5A);
    rd(ADR_SER_FIRST, 8'h5A);
    wr(ADR_SER_LAST, 8'hC3);
    wr(ADR_COMP_CTL, 8'h80);
    wr(ADR_SER_FIRST, 8'hA5);
    rd(ADR_SER_FIRST, 8'h5A);
    rd(ADR_SER_LAST, 8'hC3);
    wr(ADR_COMP_CTL, 8'h00);
    rd(ADR_COMP_CTL, 8'h80);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    reset   = 1'b1;
    ext_low = 1'b0;
    pf_lo   = 1'b0;
    sup_lo  = 1'b0;
    sup_hi  = 1'b0;
    ev_a    = 1'b0;
    ev_b    = 1'b0;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    host.hc(8);
    t_regs;
    t_wdog;
    t_sup;
    t_man;
    t_cnt;
    t_ser;
    close_out;
  end
  // Whole run is near 54k cycles
  initial begin
    #800_000;
    errors++;
    $display("BAD %0t run timed out", $time);
    close_out;
  end
endmodule

bind pcs_companion pcs_companion_assertions #(.P_RST_HOLD_CYC(P_RST_HOLD_CYC), .P_MR_FILT_CYC(P_MR_FILT_CYC)) u_chk (
  .clk_sys(clk_sys), .reset(reset), .pins_in(pins_in), .rst_out(rst_out), .rst_oe_n(rst_oe_n),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pf_warn_out(pf_warn_out));
